// ### hdl/ldc_defines.svh
`ifndef LDC_DEFINES_SVH
`define LDC_DEFINES_SVH
// ****************************************
// Register map (byte addresses)
// ****************************************
`define LDC_ADDR_BIN       6'h00
`define LDC_ADDR_RAMP     6'h04
`define LDC_ADDR_CFT      6'h08
`define LDC_ADDR_TKNEE    6'h0C
`define LDC_ADDR_TSLOPE   6'h10
`define LDC_ADDR_TCLAMP   6'h14
`define LDC_ADDR_XFER     6'h18
`define LDC_ADDR_NV_BIN   6'h20
`define LDC_ADDR_NV_RAMP  6'h24
`define LDC_ADDR_NV_CFT   6'h28
`define LDC_ADDR_NV_TKNEE 6'h2C
`define LDC_ADDR_NV_TSLP  6'h30
`define LDC_ADDR_NV_TCLMP 6'h34
`define LDC_ADDR_STATUS   6'h38
// ****************************************
// Reset values
// ****************************************
`define LDC_RST_BIN    4'hF
`define LDC_RST_RAMP   3'h7
`define LDC_RST_CFT    4'h0
`define LDC_RST_TKNEE  4'h0
`define LDC_RST_TSLOPE 2'h0
`define LDC_RST_TCLAMP 3'h0
// ****************************************
// Timing
// ****************************************
`define LDC_CLK_HZ       250000000
`define LDC_RAMP_HZ      200
`define LDC_PWM_MIN_HZ   80
`define LDC_PWM_MAX_HZ   2000
`define LDC_RAMP_PERIOD  (`LDC_CLK_HZ / `LDC_RAMP_HZ)
`define LDC_EDGE_MAX_GAP (`LDC_CLK_HZ / `LDC_PWM_MIN_HZ)
`define LDC_EDGE_MIN_GAP (`LDC_CLK_HZ / (2 * `LDC_PWM_MAX_HZ))
`define LDC_LOCK_EDGES   3
// Level in mV: offset and peak table base/step
`define LDC_DIM_OFS_MV   210
`define LDC_PEAK_MIN_MV  1550
`define LDC_PEAK_STEP_MV 190
`endif

// ### hdl/ldc_pkg.sv
`default_nettype none
package ldc_pkg;
   typedef struct packed {
      logic [3:0] bin;
      logic [2:0] ramp;
      logic [3:0] cft;
      logic [3:0] tknee;
      logic [1:0] tslope;
      logic [2:0] tclamp;
   } ldc_set_t;
   typedef enum logic [2:0] {
      LDC_ANALOG = 3'b001,
      LDC_ACQ    = 3'b010,
      LDC_LOCKED = 3'b100
   } ldc_mode_t;
endpackage
`default_nettype wire

// ### hdl/ldc_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "ldc_defines.svh"
module ldc_top #(
   parameter int RAMP_PERIOD  = `LDC_RAMP_PERIOD,
   parameter int EDGE_MAX_GAP = `LDC_EDGE_MAX_GAP,
   parameter int EDGE_MIN_GAP = `LDC_EDGE_MIN_GAP,
   parameter int LVL_W        = 12
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // Supply and pins
   input  wire logic             supply_ok,
   input  wire logic             enable_pin,
   input  wire logic             foldback_dim_enable_pin,
   input  wire logic             dimming_input,
   input  wire logic [LVL_W-1:0] dimming_input_level,
   // Avalon-MM slave
   input  wire logic [5:0]       avs_address,
   input  wire logic             avs_read,
   input  wire logic             avs_write,
   input  wire logic [31:0]      avs_writedata,
   input  wire logic [3:0]       avs_byteenable,
   output logic [31:0]           avs_readdata,
   output logic                  avs_waitrequest,
   // Outputs
   output logic                  led_on,
   output logic                  aux_5v_regulator_output,
   output logic                  foldback_active,
   output ldc_pkg::ldc_set_t     settings
);
   // ****************************************
   // Settings storage
   // ****************************************
   ldc_pkg::ldc_set_t dyn_q;
   ldc_pkg::ldc_set_t nv_q;
   logic              loaded_q;
   logic              ack_q;
   logic              wr_go;
   logic              rd_go;
   logic              xfer_go;
   logic [7:0]        wb;

   // Single wait state: every access answers one cycle after request
   assign wr_go   = avs_write && !ack_q;
   assign rd_go   = avs_read && !ack_q;
   assign wb      = avs_byteenable[0] ? avs_writedata[7:0] : 8'h00;
   assign xfer_go = wr_go && avs_byteenable[0] && (avs_address == `LDC_ADDR_XFER);

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= (avs_read || avs_write) && !ack_q;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         nv_q <= '{`LDC_RST_BIN, `LDC_RST_RAMP, `LDC_RST_CFT, `LDC_RST_TKNEE, `LDC_RST_TSLOPE, `LDC_RST_TCLAMP};
      end else if (wr_go && avs_byteenable[0]) begin
         case (avs_address)
            `LDC_ADDR_NV_BIN:   nv_q.bin    <= wb[3:0];
            `LDC_ADDR_NV_RAMP:  nv_q.ramp   <= wb[2:0];
            `LDC_ADDR_NV_CFT:   nv_q.cft    <= wb[3:0];
            `LDC_ADDR_NV_TKNEE: nv_q.tknee  <= wb[3:0];
            `LDC_ADDR_NV_TSLP:  nv_q.tslope <= wb[1:0];
            `LDC_ADDR_NV_TCLMP: nv_q.tclamp <= wb[2:0];
            default: begin
            end
         endcase
      end
   end

   // Supply loss wipes dynamic copy; restore waits for supply return
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         dyn_q    <= '0;
         loaded_q <= 1'b0;
      end else if (!supply_ok) begin
         dyn_q    <= '0;
         loaded_q <= 1'b0;
      end else if (!loaded_q || xfer_go) begin
         dyn_q    <= nv_q;
         loaded_q <= 1'b1;
      end else if (wr_go && avs_byteenable[0]) begin
         case (avs_address)
            `LDC_ADDR_BIN:    dyn_q.bin    <= wb[3:0];
            `LDC_ADDR_RAMP:   dyn_q.ramp   <= wb[2:0];
            `LDC_ADDR_CFT:    dyn_q.cft    <= wb[3:0];
            `LDC_ADDR_TKNEE:  dyn_q.tknee  <= wb[3:0];
            `LDC_ADDR_TSLOPE: dyn_q.tslope <= wb[1:0];
            `LDC_ADDR_TCLAMP: dyn_q.tclamp <= wb[2:0];
            default: begin
            end
         endcase
      end
   end

   // ****************************************
   // Pulse detector
   // ****************************************
   ldc_pkg::ldc_mode_t mode_q;
   logic               din_q;
   logic [31:0]        gap_q;
   logic [1:0]         edges_q;
   logic               edge_s;
   logic               gap_ok;

   assign edge_s = dimming_input != din_q;
   // Edge-to-edge gap spans half-period; high duty can shorten it
   assign gap_ok = gap_q >= 32'(EDGE_MIN_GAP / 2);

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         din_q   <= 1'b0;
         gap_q   <= '0;
         edges_q <= '0;
         mode_q  <= ldc_pkg::LDC_ANALOG;
      end else begin
         din_q <= dimming_input;
         if (edge_s) begin
            gap_q <= '0;
         end else if (gap_q < 32'(EDGE_MAX_GAP)) begin
            gap_q <= gap_q + 32'd1;
         end
         case (mode_q)
            ldc_pkg::LDC_ANALOG: begin
               if (edge_s) begin
                  edges_q <= 2'd1;
                  mode_q  <= ldc_pkg::LDC_ACQ;
               end
            end
            ldc_pkg::LDC_ACQ: begin
               if (gap_q >= 32'(EDGE_MAX_GAP)) begin
                  mode_q <= ldc_pkg::LDC_ANALOG;
               end else if (edge_s && !gap_ok) begin
                  edges_q <= 2'd1;
               end else if (edge_s) begin
                  edges_q <= edges_q + 2'd1;
                  if (edges_q == 2'(`LDC_LOCK_EDGES - 1)) begin
                     mode_q <= ldc_pkg::LDC_LOCKED;
                  end
               end
            end
            ldc_pkg::LDC_LOCKED: begin
               if (gap_q >= 32'(EDGE_MAX_GAP)) begin
                  mode_q <= ldc_pkg::LDC_ANALOG;
               end
            end
            default: mode_q <= ldc_pkg::LDC_ANALOG;
         endcase
      end
   end

   // ****************************************
   // Ramp generator and comparator
   // ****************************************
   logic [31:0]      ramp_cnt_q;
   logic [LVL_W-1:0] peak_mv;
   logic [LVL_W-1:0] net_mv;
   logic [47:0]      lhs;
   logic [47:0]      rhs;
   logic             ana_on;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ramp_cnt_q <= '0;
      end else if (ramp_cnt_q >= 32'(RAMP_PERIOD - 1)) begin
         ramp_cnt_q <= '0;
      end else begin
         ramp_cnt_q <= ramp_cnt_q + 32'd1;
      end
   end

   // Level in mV; peak steps with the 3-bit code
   assign peak_mv = LVL_W'(`LDC_PEAK_MIN_MV) + LVL_W'(`LDC_PEAK_STEP_MV) * LVL_W'(dyn_q.ramp);
   assign net_mv  = (dimming_input_level > LVL_W'(`LDC_DIM_OFS_MV)) ?
                    dimming_input_level - LVL_W'(`LDC_DIM_OFS_MV) : '0;
   // on while ramp/period < net/peak; saturates at 0 and 100%
   assign lhs     = 48'(ramp_cnt_q) * 48'(peak_mv);
   assign rhs     = 48'(net_mv) * 48'(RAMP_PERIOD);
   assign ana_on  = lhs < rhs;

   // ****************************************
   // Output gating
   // ****************************************
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         led_on                  <= 1'b0;
         aux_5v_regulator_output <= 1'b0;
         foldback_active         <= 1'b0;
         settings                <= '0;
      end else begin
         aux_5v_regulator_output <= enable_pin && supply_ok;
         foldback_active         <= foldback_dim_enable_pin;
         settings                <= dyn_q;
         if (!enable_pin || !supply_ok) begin
            led_on <= 1'b0;
         end else if (mode_q == ldc_pkg::LDC_LOCKED) begin
            led_on <= dimming_input;
         end else begin
            led_on <= ana_on;
         end
      end
   end

   // ****************************************
   // Read path
   // ****************************************
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         avs_readdata    <= '0;
         avs_waitrequest <= 1'b1;
      end else begin
         avs_waitrequest <= !((avs_read || avs_write) && !ack_q);
         if (rd_go) begin
            case (avs_address)
               `LDC_ADDR_BIN:      avs_readdata <= {28'h0, dyn_q.bin};
               `LDC_ADDR_RAMP:     avs_readdata <= {29'h0, dyn_q.ramp};
               `LDC_ADDR_CFT:      avs_readdata <= {28'h0, dyn_q.cft};
               `LDC_ADDR_TKNEE:    avs_readdata <= {28'h0, dyn_q.tknee};
               `LDC_ADDR_TSLOPE:   avs_readdata <= {30'h0, dyn_q.tslope};
               `LDC_ADDR_TCLAMP:   avs_readdata <= {29'h0, dyn_q.tclamp};
               `LDC_ADDR_NV_BIN:   avs_readdata <= {28'h0, nv_q.bin};
               `LDC_ADDR_NV_RAMP:  avs_readdata <= {29'h0, nv_q.ramp};
               `LDC_ADDR_NV_CFT:   avs_readdata <= {28'h0, nv_q.cft};
               `LDC_ADDR_NV_TKNEE: avs_readdata <= {28'h0, nv_q.tknee};
               `LDC_ADDR_NV_TSLP:  avs_readdata <= {30'h0, nv_q.tslope};
               `LDC_ADDR_NV_TCLMP: avs_readdata <= {29'h0, nv_q.tclamp};
               `LDC_ADDR_STATUS:   avs_readdata <= {28'h0, loaded_q, mode_q};
               default:            avs_readdata <= 32'h0000_0000;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// ### testbench/ldc_top_sva.sv
`timescale 1ns/1ns
`default_nettype none
module ldc_top_sva #(
   parameter int EDGE_MAX_GAP = 3125000,
   parameter int LVL_W        = 12
) (
   // Clock and reset
   input wire logic              clk,
   input wire logic              rst_n,
   // Pins
   input wire logic              supply_ok,
   input wire logic              enable_pin,
   input wire logic              foldback_dim_enable_pin,
   input wire logic              dimming_input,
   input wire logic [LVL_W-1:0]  dimming_input_level,
   // Bus
   input wire logic [5:0]        avs_address,
   input wire logic              avs_write,
   input wire logic              avs_read,
   input wire logic [31:0]       avs_writedata,
   input wire logic [3:0]        avs_byteenable,
   input wire logic              avs_waitrequest,
   // Outputs
   input wire logic              led_on,
   input wire logic              aux_5v_regulator_output,
   input wire logic              foldback_active,
   input wire ldc_pkg::ldc_set_t settings
);
   logic din_q;
   int   quiet_q;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Quiet time on the dim pin, to know when no lock can hold
   always_ff @(posedge clk) din_q <= dimming_input;
   always_ff @(posedge clk) quiet_q <= (!rst_n || dimming_input != din_q) ? 0 : quiet_q + 1;
   aux_follow_a:
      assert property ($past(rst_n) |-> aux_5v_regulator_output == $past(enable_pin && supply_ok))
      else $error("regulator output wrong");
   fold_follow_a:
      assert property ($past(rst_n) |-> foldback_active == $past(foldback_dim_enable_pin))
      else $error("foldback flag wrong");
   led_dark_a:
      assert property (!enable_pin [*3] |-> !led_on) else $error("led on while disabled");
   bus_answer_a:
      assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("no bus answer");
   answer_once_a:
      assert property (!avs_waitrequest |=> avs_waitrequest) else $error("answer too long");
   supply_clear_a:
      assert property (!supply_ok ##1 !supply_ok |=> settings == '0) else $error("settings kept");
   ramp_bits_a:
      assert property (avs_write && avs_waitrequest && avs_address == 6'h04 && avs_byteenable[0]
         && supply_ok |=> ##1 settings.ramp == $past(avs_writedata[2:0], 2)) else $error("ramp wrong");
   low_level_a:
      assert property (quiet_q > EDGE_MAX_GAP + 4 && dimming_input_level <= 210
         && $stable(dimming_input_level) |-> !led_on) else $error("led on below offset");
   cover property (avs_write && avs_address == 6'h18);
   cover property ($rose(led_on));
   cover property (!supply_ok);
endmodule
bind ldc_top ldc_top_sva #(
   .EDGE_MAX_GAP(EDGE_MAX_GAP),
   .LVL_W       (LVL_W)
) i_sva (
   .clk                    (clk),
   .rst_n                  (rst_n),
   .supply_ok              (supply_ok),
   .enable_pin             (enable_pin),
   .foldback_dim_enable_pin(foldback_dim_enable_pin),
   .dimming_input          (dimming_input),
   .dimming_input_level    (dimming_input_level),
   .avs_address            (avs_address),
   .avs_write              (avs_write),
   .avs_read               (avs_read),
   .avs_writedata          (avs_writedata),
   .avs_byteenable         (avs_byteenable),
   .avs_waitrequest        (avs_waitrequest),
   .led_on                 (led_on),
   .aux_5v_regulator_output(aux_5v_regulator_output),
   .foldback_active        (foldback_active),
   .settings               (settings)
);
`default_nettype wire

// ### testbench/ldc_dim_src.sv
`timescale 1ns/1ns
`default_nettype none
module ldc_dim_src (
   // Clock
   input wire logic         clk,
   // Bench control
   input wire logic         pwm_on,
   input wire logic [11:0]  level_in,
   input wire logic [7:0]   high_cycles,
   // Dim pin
   output logic             dimming_input,
   output logic [11:0]      dimming_input_level
);
   logic [7:0] cnt_q = 8'h00;
   logic       pin_q = 1'b0;
   assign dimming_input       = pin_q;
   assign dimming_input_level = level_in;
   // Period of 100 cycles keeps edge gaps inside the lock window
   always @(posedge clk) begin
      cnt_q <= (!pwm_on || cnt_q == 8'h63) ? 8'h00 : cnt_q + 8'h01;
      pin_q <= pwm_on && (cnt_q < high_cycles);
   end
endmodule
`default_nettype wire

// ### testbench/led_dimming_control_tb.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(n,e,s) begin checked++; if ((s) !== (e)) begin err_count++; $display("BAD %s exp %0h got %0h", n, e, s); end end
module led_dimming_control_tb;
   logic clk = 1'b0, rst_n = 1'b0, sup = 1'b1, en = 1'b1, fold = 1'b1, pwm = 1'b0, rd = 1'b0, wr = 1'b0;
   logic [11:0] lvl = 12'h000, dlvl;
   logic [5:0]  adr = 6'h00;
   logic [31:0] wd = 32'h0, rdat, q;
   logic [3:0]  be = 4'hF;
   logic        din, led, aux, fa, wreq;
   ldc_pkg::ldc_set_t st;
   int          err_count = 0, checked = 0, n;
   int          i;
   logic        prev;
   logic [3:0]  msk [6] = '{4'hF, 4'h7, 4'hF, 4'hF, 4'h3, 4'h7};
   always #2 clk = ~clk;
   ldc_dim_src i_src (.clk(clk), .pwm_on(pwm), .level_in(lvl), .high_cycles(8'h1E), .dimming_input(din),
      .dimming_input_level(dlvl));
   ldc_top #(.RAMP_PERIOD(1000), .EDGE_MAX_GAP(400), .EDGE_MIN_GAP(20)) i_dut (.clk(clk), .rst_n(rst_n),
      .supply_ok(sup), .enable_pin(en), .foldback_dim_enable_pin(fold), .dimming_input(din),
      .dimming_input_level(dlvl), .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
      .avs_byteenable(be), .avs_readdata(rdat), .avs_waitrequest(wreq), .led_on(led),
      .aux_5v_regulator_output(aux), .foldback_active(fa), .settings(st));
   task automatic finish_test();
      if (err_count == 0 && checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic bus(input logic [5:0] a, input logic w, input logic [31:0] d);
      int k;
      @(posedge clk);
      adr <= a;
      wr  <= w;
      rd  <= !w;
      wd  <= d;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (wreq !== 1'b0 && k < 50);
      if (wreq !== 1'b0) begin
         err_count++;
         finish_test();
      end
      q = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   task automatic duty(input logic [11:0] l, input logic [2:0] r, input int e);
      bus(6'h04, 1'b1, {29'h0, r});
      lvl <= l;
      repeat (5) @(posedge clk);
      n = 0;
      repeat (1000) begin
         @(posedge clk);
         n += (led === 1'b1);
      end
      `CHK("duty", e, n)
   endtask
   initial begin
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      bus(6'h00, 1'b0, 32'h0);
      `CHK("bin", 32'h0000000F, q)
      bus(6'h04, 1'b0, 32'h0);
      `CHK("ramp", 32'h00000007, q)
      bus(6'h38, 1'b0, 32'h0);
      `CHK("status", 32'h00000009, q)
      bus(6'h3C, 1'b0, 32'h0);
      `CHK("unmapped", 32'h00000000, q)
      // Every field, live and stored, keeps only its own width
      for (i = 0; i < 6; i++) begin
         bus(6'(i * 4), 1'b1, 32'h000000FF);
         bus(6'(i * 4), 1'b0, 32'h0);
         `CHK("dyn reg", {28'h0000000, msk[i]}, q)
         bus(6'h20 + 6'(i * 4), 1'b1, 32'h000000FF);
         bus(6'h20 + 6'(i * 4), 1'b0, 32'h0);
         `CHK("nv reg", {28'h0000000, msk[i]}, q)
      end
      bus(6'h04, 1'b1, 32'h000000FA);
      bus(6'h04, 1'b0, 32'h0);
      `CHK("ramp wr", 32'h00000002, q)
      `CHK("settings", 3'h2, st.ramp)
      be <= 4'h0;
      bus(6'h00, 1'b1, 32'h5);
      be <= 4'hF;
      bus(6'h00, 1'b0, 32'h0);
      `CHK("no lane", 32'h0000000F, q)
      bus(6'h20, 1'b1, 32'h3);
      bus(6'h24, 1'b1, 32'h5);
      bus(6'h18, 1'b1, 32'h0);
      bus(6'h00, 1'b0, 32'h0);
      `CHK("xfer bin", 32'h00000003, q)
      bus(6'h04, 1'b0, 32'h0);
      `CHK("xfer ramp", 32'h00000005, q)
      // High level would light the LED, so a dark LED proves the gate
      lvl  <= 12'd3500;
      en   <= 1'b0;
      fold <= 1'b0;
      repeat (3) @(posedge clk);
      `CHK("aux", 1'b0, aux)
      `CHK("fold", 1'b0, fa)
      `CHK("led", 1'b0, led)
      en   <= 1'b1;
      fold <= 1'b1;
      repeat (3) @(posedge clk);
      `CHK("aux on", 1'b1, aux)
      `CHK("fold on", 1'b1, fa)
      `CHK("led on", 1'b1, led)
      duty(12'd1650, 3'h7, 500);
      duty(12'd1650, 3'h0, 930);
      duty(12'd100, 3'h7, 0);
      duty(12'd3500, 3'h7, 1000);
      pwm <= 1'b1;
      repeat (400) @(posedge clk);
      bus(6'h38, 1'b0, 32'h0);
      `CHK("locked", 32'h0000000C, q)
      prev = din;
      repeat (200) begin
         @(posedge clk);
         `CHK("follow", prev, led)
         prev = din;
      end
      pwm <= 1'b0;
      repeat (500) @(posedge clk);
      bus(6'h38, 1'b0, 32'h0);
      `CHK("fallback", 32'h00000009, q)
      sup <= 1'b0;
      repeat (3) @(posedge clk);
      `CHK("cleared", 20'h00000, st)
      `CHK("aux off", 1'b0, aux)
      // Supply return alone restores the stored copy
      sup <= 1'b1;
      repeat (3) @(posedge clk);
      `CHK("restore", 3'h5, st.ramp)
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      `CHK("reload", 3'h7, st.ramp)
      finish_test();
   end
endmodule
`default_nettype wire
